/* rtl/rsp_pkg.sv */
// Constants for the terminal strap and status pin block.
// Assumes one 25 MHz clock and an active-low asynchronous reset.
package rsp_pkg;

  // ----------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------
  localparam int unsigned         ADDR_W         = 5;
  localparam int unsigned         TTSEL_W        = 3;
  localparam logic [2:0]          TTSEL_EXT      = 3'h1;
  localparam int unsigned         INIT_ADDR_W    = 15;
  localparam logic [14:0]         INIT_LAST_FULL = 15'h7fff;
  localparam logic [14:0]         INIT_LAST_1K   = 15'h03ff;
  localparam logic [14:0]         INIT_ADDR_RST  = 15'h0000;

  // ----------------------------------------------------------------
  // Reset value and SPI read command
  // ----------------------------------------------------------------
  localparam logic [4:0]          ADDR_RST       = 5'h00;
  localparam logic [7:0]          SPI_CMD_READ   = 8'h03;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned         CLK_HZ         = 25_000_000;
  localparam int unsigned         SCK_HZ         = 1_000_000;
  localparam int unsigned         SCK_HALF_CYC   = CLK_HZ / (2 * SCK_HZ);
  localparam int unsigned         SYNC_STAGES    = 2;

  typedef enum logic [1:0] {
    RSP_IDLE = 2'b00,
    RSP_CMD  = 2'b01,
    RSP_DATA = 2'b11,
    RSP_DONE = 2'b10
  } rsp_init_e;

endpackage

/* rtl/rsp_spi_shift.sv */
// SPI master byte shifter for the initialization port, mode 0.
// Assumes the caller holds chip select low around a sequence of bytes.
module rsp_spi_shift
  import rsp_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCK_HALF_CYC
) (
  // Clock, reset and enable
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  // Byte request
  input  wire logic       i_start,
  input  wire logic [7:0] i_tx,
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_rx,
  // Serial pins
  output logic            o_sck,
  output logic            o_mosi,
  input  wire logic       i_miso
);

  logic [7:0]  sh_ff;
  logic [3:0]  bits_ff;
  logic [15:0] div_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_ff   <= 8'h00;
      bits_ff <= 4'h0;
      div_ff  <= 16'h0000;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
      o_rx    <= 8'h00;
      o_sck   <= 1'b0;
      o_mosi  <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (!o_busy) begin
        if (i_start) begin
          sh_ff   <= i_tx;
          o_mosi  <= i_tx[7];
          bits_ff <= 4'h8;
          div_ff  <= 16'h0000;
          o_busy  <= 1'b1;
        end
      end else if (div_ff == 16'(HALF_CYC - 1)) begin
        div_ff <= 16'h0000;
        o_sck  <= ~o_sck;
        // Sample on the falling edge: the synchronised input lags two
        // clocks, so a rising-edge sample would see the previous bit.
        // Needs HALF_CYC of 2 or more.
        if (o_sck) begin
          sh_ff   <= {sh_ff[6:0], i_miso};
          bits_ff <= bits_ff - 4'h1;
          o_mosi  <= sh_ff[6];
          if (bits_ff == 4'h1) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
            o_rx   <= {sh_ff[6:0], i_miso};
          end
        end
      end else begin
        div_ff <= div_ff + 16'h0001;
      end
    end
  end

endmodule

/* rtl/rsp_strap_status.sv */
// Strap capture, transmit inhibit, ready/active and init SPI pins.
// Assumes straps and pin inputs are asynchronous to i_clk.
module rsp_strap_status_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_ff <= '0;
      o_q   <= '0;
    end else if (i_ce) begin
      s1_ff <= i_d;
      o_q   <= s1_ff;
    end
  end
endmodule

module rsp_strap_status
  import rsp_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCK_HALF_CYC
) (
  // Clock, reset, enable
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  // Straps
  input  wire logic [4:0]   i_terminal_address_straps,
  input  wire logic         i_terminal_address_parity_strap,
  input  wire logic         i_lock_strap,
  input  wire logic         i_auto_init_strap,
  input  wire logic         i_init_range_strap,
  // Host address write
  input  wire logic         i_addr_wr,
  input  wire logic [4:0]   i_addr_wr_data,
  input  wire logic         i_addr_wr_parity,
  // Configuration bits
  input  wire logic         i_cfg_bus_a_inhibit,
  input  wire logic         i_cfg_bus_b_inhibit,
  input  wire logic [2:0]   i_time_tag_clock_select,
  input  wire logic         i_start_execution_bit,
  // Pins and engine status
  input  wire logic         i_bus_a_transmit_inhibit,
  input  wire logic         i_bus_b_transmit_inhibit,
  input  wire logic         i_time_tag_clock_in,
  input  wire logic         i_subsystem_fail_in,
  input  wire logic         i_self_test_busy,
  input  wire logic         i_cmd_busy,
  // Status outputs
  output logic [4:0]        o_terminal_address,
  output logic              o_terminal_address_parity,
  output logic              o_lock,
  output logic              o_bus_a_tx_blocked,
  output logic              o_bus_b_tx_blocked,
  output logic              o_ready,
  output logic              o_active,
  output logic              o_run,
  output logic              o_time_tag_tick,
  output logic              o_subsystem_flag,
  // Init load stream
  output logic              o_init_wr,
  output logic [14:0]       o_init_addr,
  output logic [7:0]        o_init_data,
  // Init SPI port
  output logic              o_init_port_chip_select_n,
  output logic              o_init_port_serial_clock,
  output logic              o_mosi,
  input  wire logic         i_miso
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic rst_s1_ff;
  logic rst_n_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  localparam int unsigned PIN_W = 14;
  logic [PIN_W-1:0] pins_s;
  rsp_strap_status_sync #(.W(PIN_W)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n_ff),
    .i_ce    (i_ce),
    .i_d     ({i_terminal_address_straps, i_terminal_address_parity_strap,
               i_lock_strap, i_auto_init_strap, i_init_range_strap,
               i_bus_a_transmit_inhibit, i_bus_b_transmit_inhibit,
               i_time_tag_clock_in, i_subsystem_fail_in, i_miso}),
    .o_q     (pins_s)
  );
  wire logic [4:0] s_addr   = pins_s[13:9];
  wire logic       s_par    = pins_s[8];
  wire logic       s_lock   = pins_s[7];
  wire logic       s_auto   = pins_s[6];
  wire logic       s_range  = pins_s[5];
  wire logic       s_inh_a  = pins_s[4];
  wire logic       s_inh_b  = pins_s[3];
  wire logic       s_time_tag_clock_in  = pins_s[2];
  wire logic       s_ssf    = pins_s[1];
  wire logic       s_miso   = pins_s[0];

  // Straps are taken once, when the synchronised pins are valid
  logic [1:0] cap_cnt_ff;
  logic       cap_done_ff;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cap_cnt_ff  <= 2'h0;
      cap_done_ff <= 1'b0;
    end else if (i_ce && !cap_done_ff) begin
      cap_cnt_ff <= cap_cnt_ff + 2'h1;
      if (cap_cnt_ff == 2'(SYNC_STAGES)) begin
        cap_done_ff <= 1'b1;
      end
    end
  end
  wire logic cap_now = i_ce && !cap_done_ff
                       && (cap_cnt_ff == 2'(SYNC_STAGES));

  // ----------------------------------------------------------------
  // Operational status address, parity and lock
  // ----------------------------------------------------------------
  logic auto_ff;
  logic range_ff;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_terminal_address        <= ADDR_RST;
      o_terminal_address_parity <= 1'b0;
      o_lock                    <= 1'b0;
      auto_ff                   <= 1'b0;
      range_ff                  <= 1'b0;
    end else if (cap_now) begin
      o_terminal_address        <= s_addr;
      o_terminal_address_parity <= s_par;
      o_lock                    <= s_lock;
      auto_ff                   <= s_auto;
      range_ff                  <= s_range;
    end else if (i_ce && cap_done_ff && i_addr_wr && !o_lock) begin
      o_terminal_address        <= i_addr_wr_data;
      o_terminal_address_parity <= i_addr_wr_parity;
    end
  end

  // ----------------------------------------------------------------
  // Inhibit, subsystem, time tag, active
  // ----------------------------------------------------------------
  logic time_tag_clock_in_d_ff;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_bus_a_tx_blocked <= 1'b0;
      o_bus_b_tx_blocked <= 1'b0;
      o_subsystem_flag   <= 1'b0;
      o_active           <= 1'b0;
      time_tag_clock_in_d_ff         <= 1'b0;
      o_time_tag_tick    <= 1'b0;
    end else if (i_ce) begin
      o_bus_a_tx_blocked <= s_inh_a | i_cfg_bus_a_inhibit;
      o_bus_b_tx_blocked <= s_inh_b | i_cfg_bus_b_inhibit;
      o_subsystem_flag   <= s_ssf;
      o_active           <= o_run & i_cmd_busy;
      time_tag_clock_in_d_ff         <= s_time_tag_clock_in;
      // External rising edge, or every clock when internal
      o_time_tag_tick    <= (i_time_tag_clock_select == TTSEL_EXT)
                            ? (s_time_tag_clock_in & ~time_tag_clock_in_d_ff) : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Auto-initialization sequence
  // ----------------------------------------------------------------
  rsp_init_e   st_ff;
  logic [14:0] addr_ff;
  logic        start_ff;
  logic [7:0]  tx_ff;
  logic        spi_busy;
  logic        spi_done;
  logic [7:0]  spi_rx;
  logic [1:0]  cmd_idx_ff;

  rsp_spi_shift #(.HALF_CYC(HALF_CYC)) u_spi (
    .i_clk   (i_clk),
    .i_rst_n (rst_n_ff),
    .i_ce    (i_ce),
    .i_start (start_ff),
    .i_tx    (tx_ff),
    .o_busy  (spi_busy),
    .o_done  (spi_done),
    .o_rx    (spi_rx),
    .o_sck   (o_init_port_serial_clock),
    .o_mosi  (o_mosi),
    .i_miso  (s_miso)
  );

  wire logic [14:0] last_addr = range_ff ? INIT_LAST_1K : INIT_LAST_FULL;

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff                     <= RSP_IDLE;
      addr_ff                   <= INIT_ADDR_RST;
      start_ff                  <= 1'b0;
      tx_ff                     <= 8'h00;
      cmd_idx_ff                <= 2'h0;
      o_init_port_chip_select_n <= 1'b1;
      o_init_wr                 <= 1'b0;
      o_init_addr               <= INIT_ADDR_RST;
      o_init_data               <= 8'h00;
      o_ready                   <= 1'b0;
    end else if (i_ce) begin
      start_ff  <= 1'b0;
      o_init_wr <= 1'b0;
      o_ready   <= cap_done_ff && !i_self_test_busy
                   && (st_ff == RSP_DONE || st_ff == RSP_IDLE)
                   && !cap_now && !(st_ff == RSP_IDLE && auto_ff);
      unique case (st_ff)
        RSP_IDLE: begin
          if (cap_done_ff && auto_ff) begin
            o_init_port_chip_select_n <= 1'b0;
            tx_ff      <= SPI_CMD_READ;
            start_ff   <= 1'b1;
            cmd_idx_ff <= 2'h0;
            st_ff      <= RSP_CMD;
          end else if (cap_done_ff) begin
            st_ff <= RSP_DONE;
          end
        end
        RSP_CMD: begin
          if (spi_done) begin
            cmd_idx_ff <= cmd_idx_ff + 2'h1;
            start_ff   <= 1'b1;
            tx_ff      <= 8'h00; // Start address zero, then dummy bytes
            if (cmd_idx_ff == 2'h2) begin
              st_ff <= RSP_DATA;
            end
          end
        end
        RSP_DATA: begin
          if (spi_done) begin
            o_init_wr   <= 1'b1;
            o_init_addr <= addr_ff;
            o_init_data <= spi_rx;
            if (addr_ff == last_addr) begin
              o_init_port_chip_select_n <= 1'b1;
              st_ff <= RSP_DONE;
            end else begin
              addr_ff  <= addr_ff + 15'h0001;
              start_ff <= 1'b1;
            end
          end
        end
        RSP_DONE: begin
          o_init_port_chip_select_n <= 1'b1;
        end
      endcase
    end
  end

  // Terminal runs only once ready and host set start
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_run <= 1'b0;
    end else if (i_ce) begin
      o_run <= o_ready & i_start_execution_bit;
    end
  end

endmodule

/* sim/rsp_eeprom_model.sv */
// Serial EEPROM slave on the init port, mode 0, byte n holds n ^ 0xa5.
// Assumes the device is master and drives chip select and clock.
module rsp_eeprom_model (
  // Pins from the device
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  // Data back and command seen
  output logic       o_miso,
  output logic [7:0] o_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned nbit = 0;
  logic [7:0]  cur;
  // ----
  // Command capture and data shift-out
  // ----
  always @(negedge i_cs_n) begin
    nbit = 0;
    o_cmd = 8'h00;
  end
  always @(posedge i_sck) begin
    if (!i_cs_n) begin
      if (nbit < 8) o_cmd = {o_cmd[6:0], i_mosi};
      nbit = nbit + 1;
    end
  end
  // Released line falls to the pull-down level
  always @(posedge i_cs_n) o_miso = 1'b0;
  always @(negedge i_sck) begin
    if (!i_cs_n && nbit < 24) o_miso = nbit[0];
    else if (!i_cs_n) begin
      cur = 8'((nbit - 24) / 8) ^ 8'ha5;
      o_miso = cur[7 - (nbit - 24) % 8];
    end
  end
endmodule

/* sim/rsp_strap_status_assertions.sv */
// Port checks of the strap and status block.
// Assumes one clock domain and the async active-low reset.
module rsp_strap_status_assertions
  import rsp_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // Inputs
  input wire logic        i_addr_wr,
  input wire logic [4:0]  i_addr_wr_data,
  input wire logic        i_addr_wr_parity,
  input wire logic        i_cfg_bus_a_inhibit,
  input wire logic        i_cfg_bus_b_inhibit,
  input wire logic        i_bus_a_transmit_inhibit,
  input wire logic        i_bus_b_transmit_inhibit,
  input wire logic [2:0]  i_time_tag_clock_select,
  input wire logic        i_start_execution_bit,
  input wire logic        i_cmd_busy,
  input wire logic        i_subsystem_fail_in,
  input wire logic        i_init_range_strap,
  // Outputs
  input wire logic [4:0]  o_terminal_address,
  input wire logic        o_terminal_address_parity,
  input wire logic        o_lock,
  input wire logic        o_bus_a_tx_blocked,
  input wire logic        o_bus_b_tx_blocked,
  input wire logic        o_ready,
  input wire logic        o_active,
  input wire logic        o_run,
  input wire logic        o_time_tag_tick,
  input wire logic        o_subsystem_flag,
  input wire logic        o_init_wr,
  input wire logic [14:0] o_init_addr,
  input wire logic        o_init_port_chip_select_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----
  // Assertions
  // ----
  AST_LOCK_HOLD: assert property ($past(o_lock) && o_lock |->
    $stable(o_terminal_address)) else $error("address moved while locked");
  AST_ADDR_WR: assert property (i_addr_wr && !o_lock && o_ready |=>
    {o_terminal_address, o_terminal_address_parity} ==
    $past({i_addr_wr_data, i_addr_wr_parity})) else $error("write lost");
  AST_TX_BLOCK: assert property (o_ready && $past(o_ready, 3) |->
    {o_bus_a_tx_blocked, o_bus_b_tx_blocked} ==
    ($past({i_cfg_bus_a_inhibit, i_cfg_bus_b_inhibit}) |
    $past({i_bus_a_transmit_inhibit, i_bus_b_transmit_inhibit}, 3)))
    else $error("inhibit wrong");
  AST_ACTIVE: assert property (o_active ==
    ($past(o_run) && $past(i_cmd_busy))) else $error("active wrong");
  AST_RUN: assert property (o_run |->
    $past(o_ready) && $past(i_start_execution_bit)) else $error("early run");
  AST_READY_INIT: assert property (!o_init_port_chip_select_n |->
    !o_ready) else $error("ready during init");
  AST_TT_INT: assert property ((o_ready &&
    i_time_tag_clock_select != TTSEL_EXT) [*3] |-> o_time_tag_tick)
    else $error("no internal tick");
  AST_SUBSYSTEM_FLAG: assert property (o_ready && $past(o_ready, 3) |->
    o_subsystem_flag == $past(i_subsystem_fail_in, 3)) else $error("flag");
  AST_RANGE: assert property (o_init_wr && i_init_range_strap |->
    o_init_addr <= INIT_LAST_1K) else $error("load out of range");
  COV_LAST: cover property (o_init_wr && o_init_addr == INIT_LAST_1K);
  COV_ACT: cover property (o_active);
  COV_LOCKED_WR: cover property (o_lock && i_addr_wr);
endmodule
bind rsp_strap_status rsp_strap_status_assertions u_chk (.*);

/* sim/rsp_strap_status_tb.sv */
// Self-checking bench for the strap and status block.
// Assumes the EEPROM model answers on the init port.
module rsp_strap_status_tb
  import rsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_miso;
  logic        i_terminal_address_parity_strap = 1'b0, i_lock_strap = 1'b0;
  logic        i_auto_init_strap = 1'b0, i_init_range_strap = 1'b1;
  logic        i_addr_wr = 1'b0, i_addr_wr_parity = 1'b0, i_cmd_busy = 1'b0;
  logic        i_cfg_bus_a_inhibit = 1'b0, i_cfg_bus_b_inhibit = 1'b0;
  logic        i_bus_a_transmit_inhibit = 1'b0, i_bus_b_transmit_inhibit = 1'b0;
  logic        i_start_execution_bit = 1'b0, i_time_tag_clock_in = 1'b0;
  logic        i_subsystem_fail_in = 1'b0, i_self_test_busy = 1'b0;
  logic [4:0]  i_terminal_address_straps = 5'h00, i_addr_wr_data = 5'h00;
  logic [2:0]  i_time_tag_clock_select = 3'h0;
  logic [4:0]  o_terminal_address;
  logic        o_terminal_address_parity, o_lock, o_bus_a_tx_blocked;
  logic        o_bus_b_tx_blocked, o_ready, o_active, o_run, o_time_tag_tick;
  logic        o_subsystem_flag, o_init_wr, o_init_port_chip_select_n;
  logic        o_init_port_serial_clock, o_mosi;
  logic [14:0] o_init_addr, last_addr;
  logic [7:0]  o_init_data, cmd;
  int          fails = 0, cmp_count = 0, nwr = 0, bad = 0;
  // ----
  // Design, EEPROM and load stream monitor
  // ----
  rsp_strap_status #(.HALF_CYC(2)) uut (.*);
  rsp_eeprom_model eep (.i_cs_n(o_init_port_chip_select_n),
    .i_sck(o_init_port_serial_clock), .i_mosi(o_mosi), .o_miso(i_miso),
    .o_cmd(cmd));
  always #20 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    if (o_init_wr === 1'b1) begin
      if (o_init_data !== (o_init_addr[7:0] ^ 8'ha5)) bad++;
      if (o_init_addr !== 15'(nwr)) bad++;
      last_addr = o_init_addr;
      nwr++;
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset(input logic [4:0] a, input logic lk, input logic au);
    int n;
    i_rst_n = 1'b0;
    i_terminal_address_straps = a;
    i_terminal_address_parity_strap = ~^a;
    i_lock_strap = lk;
    i_auto_init_strap = au;
    nwr = 0;
    cyc(16);
    i_rst_n = 1'b1;
    for (n = 0; n < 45000 && o_ready !== 1'b1; n++) cyc(1);
    if (o_ready !== 1'b1) begin
      fails++;
      close_out();
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_init();
    do_reset(5'h15, 1'b0, 1'b1);
    check(16'(nwr), 16'd1024);
    check(16'(last_addr), 16'(INIT_LAST_1K));
    check(16'(bad), 16'h0000);
    check(16'(cmd), 16'(SPI_CMD_READ));
    check(16'(o_init_port_chip_select_n), 16'h0001);
    check({o_lock, o_terminal_address_parity, o_terminal_address},
      16'h0015);
    i_terminal_address_straps = 5'h0a;
    cyc(6);
    check(16'(o_terminal_address), 16'h0015);
  endtask
  task automatic t_write();
    i_addr_wr = 1'b1;
    i_addr_wr_data = 5'h03;
    i_addr_wr_parity = 1'b1;
    cyc(1);
    check({o_terminal_address_parity, o_terminal_address}, 16'h0023);
    i_addr_wr_data = 5'h1c;
    i_addr_wr_parity = 1'b0;
    cyc(1);
    i_addr_wr = 1'b0;
    check({o_terminal_address_parity, o_terminal_address}, 16'h001c);
  endtask
  task automatic t_inh();
    for (int i = 0; i < 16; i++) begin
      {i_bus_a_transmit_inhibit, i_bus_b_transmit_inhibit,
        i_cfg_bus_a_inhibit, i_cfg_bus_b_inhibit} = 4'(i);
      cyc(4);
      check({o_bus_a_tx_blocked, o_bus_b_tx_blocked},
        {14'h0000, i[3] | i[1], i[2] | i[0]});
    end
  endtask
  task automatic t_ready();
    i_self_test_busy = 1'b1;
    cyc(6);
    check(16'(o_ready), 16'h0000);
    i_self_test_busy = 1'b0;
    i_cmd_busy = 1'b1;
    cyc(6);
    check({o_ready, o_run, o_active}, 16'h0004);
    i_start_execution_bit = 1'b1;
    cyc(3);
    check({o_ready, o_run, o_active}, 16'h0007);
    i_cmd_busy = 1'b0;
    cyc(3);
    check({o_ready, o_run, o_active}, 16'h0006);
  endtask
  task automatic t_tt();
    int n;
    for (int s = 0; s < 8; s++) begin
      i_time_tag_clock_select = 3'(s);
      cyc(6);
      check(16'(o_time_tag_tick), 16'(s != 1));
    end
    // Back to the external source before pulsing the pin
    i_time_tag_clock_select = TTSEL_EXT;
    n = 0;
    i_time_tag_clock_in = 1'b1;
    repeat (8) begin
      cyc(1);
      n += int'(o_time_tag_tick === 1'b1);
    end
    i_time_tag_clock_in = 1'b0;
    check(16'(n), 16'h0001);
  endtask
  task automatic t_sub();
    i_subsystem_fail_in = 1'b1;
    cyc(4);
    check(16'(o_subsystem_flag), 16'h0001);
    i_subsystem_fail_in = 1'b0;
    cyc(4);
    check(16'(o_subsystem_flag), 16'h0000);
  endtask
  task automatic t_lock();
    do_reset(5'h09, 1'b1, 1'b0);
    check({o_lock, o_terminal_address_parity, o_terminal_address},
      16'h0069);
    i_addr_wr = 1'b1;
    i_addr_wr_data = 5'h1f;
    cyc(2);
    i_addr_wr = 1'b0;
    check(16'(o_terminal_address), 16'h0009);
  endtask
  initial begin
    cyc(1);
    t_init();
    t_write();
    t_inh();
    t_ready();
    t_tt();
    t_sub();
    t_lock();
    close_out();
  end
endmodule
